// >>> logic/tphp_pkg.sv
package tphp_pkg;
   // samples are unsigned, one lsb = 0.1 degree
   localparam int          SMP_W       = 16;
   localparam logic [5:0]  OFS_CTRL    = 6'h00;
   localparam logic [5:0]  OFS_SUB_LO  = 6'h04;
   localparam logic [5:0]  OFS_FULL_LO = 6'h08;
   localparam logic [5:0]  OFS_CLR_INT = 6'h0C;
   localparam logic [5:0]  OFS_DECAY   = 6'h10;
   localparam logic [5:0]  OFS_DELAY   = 6'h14;
   localparam logic [5:0]  OFS_RBT     = 6'h18;
   localparam logic [5:0]  OFS_VALUE   = 6'h1C;
   localparam logic [5:0]  OFS_STATUS  = 6'h20;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
   // ctrl fields
   localparam int          MODE_LSB    = 0;
   localparam int          UNIT_BIT    = 2;
   localparam logic [1:0]  MODE_OFF    = 2'h0;
   localparam logic [1:0]  MODE_AUTO   = 2'h1;
   localparam logic [1:0]  MODE_CLR    = 2'h2;
   localparam logic [1:0]  MODE_SMART  = 2'h3;
   // timing: one tick per 10 ms, intervals counted in ticks
   localparam int          CLK_HZ      = 25000000;
   localparam int          TICK_MS     = 10;
   localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
   localparam int          CLR_MAX_MS  = 25000;
   localparam int          DLY_MIN_MS  = 20;
   localparam int          DLY_MAX_MS  = 10000;
   localparam logic [15:0] CLR_MAX     = 16'(CLR_MAX_MS / TICK_MS);
   localparam logic [15:0] DLY_MIN     = 16'(DLY_MIN_MS / TICK_MS);
   localparam logic [15:0] DLY_MAX     = 16'(DLY_MAX_MS / TICK_MS);
   // decay rate in 0.01 degree/s; per tick step = rate / 1000 lsb
   localparam logic [15:0] RATE_MAX_C  = 16'h411A;
   localparam logic [15:0] RATE_MAX_F  = 16'h7530;
   localparam logic [16:0] RATE_DIV    = 17'h003E8;
   localparam logic [15:0] HOT_MARGIN  = 16'h000A;
   localparam logic [15:0] FULL_MARGIN = 16'h0001;
   localparam logic [15:0] FULL_LO_RST = 16'h0000;
   typedef enum logic [1:0] {SM_IDLE, SM_DELAY, SM_PEAK} tphp_smart_e;
endpackage

// >>> logic/tphp_tick.sv
module tphp_tick
   import tphp_pkg::*;
#(
   parameter int CYC = TICK_CYC
)(
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   output logic      tick_out
);
   localparam int CW = $clog2(CYC);
   logic [CW-1:0] cnt_q;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         cnt_q    <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         tick_out <= (cnt_q == CW'(CYC - 1));
         cnt_q    <= (cnt_q == CW'(CYC - 1)) ? '0 : cnt_q + 1'b1;
      end
   end
endmodule // tphp_tick

// >>> logic/tphp_decay.sv
module tphp_decay
   import tphp_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        tick_in,
   input  wire logic        restart_in,
   input  wire logic [15:0] rate_in,
   output logic      [5:0]  step_out,
   output logic             step_vld_out
);
   // fractional remainder carried so slow rates still decay
   logic [15:0] frac_q;
   logic [16:0] sum;
   logic [16:0] quo;

   assign sum = {1'b0, frac_q} + {1'b0, rate_in};
   assign quo = sum / RATE_DIV;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || restart_in)
      begin
         frac_q       <= '0;
         step_out     <= '0;
         step_vld_out <= 1'b0;
      end
      else
      begin
         step_vld_out <= tick_in;
         if (tick_in)
         begin
            step_out <= 6'(quo);
            frac_q   <= 16'(sum - 17'(quo * RATE_DIV));
         end
      end
   end
endmodule // tphp_decay

// >>> logic/tphp_picker.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
module tphp_picker
   import tphp_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire logic [SMP_W-1:0] sample_in,
   input  wire logic             sample_valid_in,
   output logic      [SMP_W-1:0] value_out,
   output logic                  value_valid_out,
   input  wire logic [31:0]      s_axi_awaddr_in,
   input  wire logic             s_axi_awvalid_in,
   output logic                  s_axi_awready_out,
   input  wire logic [31:0]      s_axi_wdata_in,
   input  wire logic [3:0]       s_axi_wstrb_in,
   input  wire logic             s_axi_wvalid_in,
   output logic                  s_axi_wready_out,
   output logic      [1:0]       s_axi_bresp_out,
   output logic                  s_axi_bvalid_out,
   input  wire logic             s_axi_bready_in,
   input  wire logic [31:0]      s_axi_araddr_in,
   input  wire logic             s_axi_arvalid_in,
   output logic                  s_axi_arready_out,
   output logic      [31:0]      s_axi_rdata_out,
   output logic      [1:0]       s_axi_rresp_out,
   output logic                  s_axi_rvalid_out,
   input  wire logic             s_axi_rready_in
);
   function automatic logic mapped(input logic [31:0] a);
      return (a[31:6] == 26'h0) && (a[1:0] == 2'h0) &&
             (a[5:2] <= OFS_STATUS[5:2]);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      // zero is kept: it means off
      return (v == 16'h0) ? v : (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction

   function automatic logic [15:0] max16(input logic [15:0] a,
                                         input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction

   logic [1:0]  mode_q;
   logic        unit_q;
   logic [15:0] sub_lo_q;
   logic [15:0] full_lo_q;
   logic [15:0] clr_int_q;
   logic [15:0] rate_q;
   logic [15:0] dly_q;
   logic [15:0] rbt_q;
   logic [15:0] held_q;
   logic [15:0] prev_q;
   logic        armed_q;
   logic [15:0] ci_cnt_q;
   logic [15:0] dcnt_q;
   tphp_smart_e st_q;
   logic        wr_fire;
   logic        wr_ctrl;
   logic        tick;
   logic [5:0]  step;
   logic        step_vld;
   logic        is_auto;
   logic        is_clr;
   logic        is_smart;
   logic        peak_hold_enable;
   logic        roll;
   logic        hot_new;
   logic        above;
   logic [15:0] lim;
   logic [15:0] margin;
   logic [15:0] rate_eff;
   logic [15:0] dec;
   logic [15:0] out_d;

   assign is_auto          = (mode_q == MODE_AUTO);
   assign is_clr           = (mode_q == MODE_CLR);
   assign is_smart         = (mode_q == MODE_SMART);
   assign peak_hold_enable = (mode_q != MODE_OFF);
   assign wr_fire          = s_axi_awready_out;
   assign wr_ctrl = wr_fire && (s_axi_awaddr_in[5:0] == OFS_CTRL) &&
                    mapped(s_axi_awaddr_in);

   // write channel: aw and w taken together, then one response
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         if (!s_axi_bvalid_out && !s_axi_awready_out &&
             s_axi_awvalid_in && s_axi_wvalid_in)
         begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
         end
         if (wr_fire)
         begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= mapped(s_axi_awaddr_in) ?
                                RESP_OKAY : RESP_DECERR;
         end
         else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
      end
   end

   // read channel
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= '0;
         s_axi_rresp_out   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out &&
                              s_axi_arvalid_in;
         if (s_axi_arready_out)
         begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= mapped(s_axi_araddr_in) ?
                                RESP_OKAY : RESP_DECERR;
            s_axi_rdata_out  <= '0;
            if (mapped(s_axi_araddr_in))
               case (s_axi_araddr_in[5:0])
                  OFS_CTRL:    s_axi_rdata_out <= {29'h0, unit_q, mode_q};
                  OFS_SUB_LO:  s_axi_rdata_out <= {16'h0, sub_lo_q};
                  OFS_FULL_LO: s_axi_rdata_out <= {16'h0, full_lo_q};
                  OFS_CLR_INT: s_axi_rdata_out <= {16'h0, clr_int_q};
                  OFS_DECAY:   s_axi_rdata_out <= {16'h0, rate_q};
                  OFS_DELAY:   s_axi_rdata_out <= {16'h0, dly_q};
                  OFS_RBT:     s_axi_rdata_out <= {16'h0, rbt_q};
                  OFS_VALUE:   s_axi_rdata_out <= {16'h0, value_out};
                  OFS_STATUS:  s_axi_rdata_out <= {28'h0, peak_hold_enable,
                                                   armed_q, 2'(st_q)};
                  default:     s_axi_rdata_out <= '0;
               endcase
         end
         else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
      end
   end

   // configuration; one mode field makes the modes exclusive
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         mode_q    <= MODE_OFF;
         unit_q    <= 1'b0;
         sub_lo_q  <= '0;
         full_lo_q <= FULL_LO_RST;
         clr_int_q <= '0;
         rate_q    <= '0;
         dly_q     <= '0;
         rbt_q     <= '0;
      end
      else if (wr_fire && mapped(s_axi_awaddr_in))
      begin
         case (s_axi_awaddr_in[5:0])
            OFS_CTRL:
            begin
               if (s_axi_wstrb_in[0])
               begin
                  mode_q <= s_axi_wdata_in[MODE_LSB +: 2];
                  unit_q <= s_axi_wdata_in[UNIT_BIT];
               end
            end
            OFS_SUB_LO:
               sub_lo_q <= merge(sub_lo_q, s_axi_wdata_in, s_axi_wstrb_in);
            OFS_FULL_LO:
               full_lo_q <= merge(full_lo_q, s_axi_wdata_in,
                                  s_axi_wstrb_in);
            OFS_CLR_INT:
               clr_int_q <= clamp(merge(clr_int_q, s_axi_wdata_in,
                                        s_axi_wstrb_in),
                                  16'h0001, CLR_MAX);
            OFS_DECAY:
               rate_q <= merge(rate_q, s_axi_wdata_in, s_axi_wstrb_in);
            OFS_DELAY:
               dly_q <= clamp(merge(dly_q, s_axi_wdata_in, s_axi_wstrb_in),
                              DLY_MIN, DLY_MAX);
            OFS_RBT:
               rbt_q <= merge(rbt_q, s_axi_wdata_in, s_axi_wstrb_in);
            default:
            begin
            end
         endcase
      end
   end

   tphp_tick #(
      .CYC (TICK_CYCLES)
   ) u_tick (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .tick_out    (tick)
   );

   // rate limited by unit so a stale setting cannot overshoot
   assign rate_eff = (rate_q > (unit_q ? RATE_MAX_F : RATE_MAX_C)) ?
                     (unit_q ? RATE_MAX_F : RATE_MAX_C) : rate_q;

   tphp_decay u_decay (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .tick_in      (tick),
      .restart_in   (st_q != SM_PEAK),
      .rate_in      (rate_eff),
      .step_out     (step),
      .step_vld_out (step_vld)
   );

   // interval counter, ticks since last clear
   assign roll = is_clr && (clr_int_q != 16'h0) && tick &&
                 (ci_cnt_q >= clr_int_q - 16'h0001);

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || !is_clr)
         ci_cnt_q <= '0;
      else if (roll)
         ci_cnt_q <= '0;
      else if (tick)
         ci_cnt_q <= ci_cnt_q + 16'h0001;
   end

   // auto: hot threshold, 1 degree above sub-range low limit, or 0.1 degree above full-range low limit when sub-range low limit is 0
   assign lim     = (sub_lo_q != 16'h0) ? sub_lo_q : full_lo_q;
   assign margin  = (sub_lo_q != 16'h0) ? HOT_MARGIN : FULL_MARGIN;
   assign hot_new = armed_q && ({1'b0, sample_in} >=
                    {1'b0, lim} + {1'b0, margin});
   assign above   = (sample_in > rbt_q);
   assign dec     = !step_vld ? held_q :
                    (held_q > 16'(step)) ? held_q - 16'(step) : 16'h0;

   // peak state
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || wr_ctrl)
      begin
         held_q  <= '0;
         prev_q  <= '0;
         armed_q <= 1'b1;
         st_q    <= SM_IDLE;
         dcnt_q  <= '0;
      end
      else
      begin
         unique case (mode_q)
            MODE_OFF:
            begin
            end
            MODE_AUTO:
            begin
               if (sample_valid_in && hot_new)
               begin
                  held_q  <= sample_in;
                  armed_q <= 1'b0;
               end
               else if (sample_valid_in)
               begin
                  held_q <= max16(held_q, sample_in);
                  if (sample_in <= lim)
                     armed_q <= 1'b1;
               end
            end
            MODE_CLR:
            begin
               if (roll)
               begin
                  prev_q <= sample_valid_in ?
                            max16(held_q, sample_in) : held_q;
                  held_q <= sample_valid_in ? sample_in : 16'h0;
               end
               else if (sample_valid_in)
                  held_q <= max16(held_q, sample_in);
            end
            MODE_SMART:
            begin
               unique case (st_q)
                  SM_IDLE:
                  begin
                     if (sample_valid_in && above && dly_q == 16'h0)
                     begin
                        st_q   <= SM_PEAK;
                        held_q <= sample_in;
                     end
                     else if (sample_valid_in && above)
                     begin
                        st_q   <= SM_DELAY;
                        dcnt_q <= '0;
                     end
                  end
                  SM_DELAY:
                  begin
                     if (sample_valid_in && !above)
                        st_q <= SM_IDLE;
                     else if (tick && dcnt_q >= dly_q - 16'h0001)
                     begin
                        st_q   <= SM_PEAK;
                        held_q <= sample_valid_in ? sample_in : 16'h0;
                     end
                     else if (tick)
                        dcnt_q <= dcnt_q + 16'h0001;
                  end
                  SM_PEAK:
                  begin
                     if (sample_valid_in && !above)
                     begin
                        st_q   <= SM_IDLE;
                        held_q <= '0;
                     end
                     else if (sample_valid_in)
                        held_q <= max16(dec, sample_in);
                     else
                        held_q <= dec;
                  end
               endcase
            end
         endcase
      end
   end

   // value presented with each sample
   always_comb
   begin
      out_d = sample_in;
      unique case (mode_q)
         MODE_OFF:
            out_d = sample_in;
         MODE_AUTO:
            out_d = hot_new ? sample_in : max16(held_q, sample_in);
         MODE_CLR:
            if (clr_int_q == 16'h0)
               out_d = sample_in;
            else if (roll)
               out_d = max16(held_q, sample_in);
            else
               out_d = prev_q;
         MODE_SMART:
            if (st_q == SM_PEAK && above)
               out_d = max16(dec, sample_in);
            else
               out_d = sample_in;
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         value_out       <= '0;
         value_valid_out <= 1'b0;
      end
      else
      begin
         value_valid_out <= sample_valid_in;
         if (sample_valid_in)
            value_out <= out_d;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence wr_take;
      s_axi_awvalid_in && s_axi_wvalid_in &&
      !s_axi_awready_out && !s_axi_bvalid_out;
   endsequence
   sequence dly_start;
      is_smart && st_q == SM_IDLE && sample_valid_in && above &&
      dly_q != 16'h0 && !wr_ctrl;
   endsequence

   axi_write_a: assert property (wr_take |=> s_axi_awready_out
      ##1 s_axi_bvalid_out) else $error("write not answered");
   mode_stable_a: assert property (!wr_ctrl |=> $stable(mode_q))
      else $error("mode changed without write");
   auto_clear_a: assert property (is_auto && sample_valid_in &&
      hot_new && !wr_ctrl |=> value_out == $past(sample_in) && !armed_q)
      else $error("auto hold not cleared");
   hold_max_a: assert property (is_auto && sample_valid_in &&
      !wr_ctrl |=> held_q >= $past(sample_in))
      else $error("held below sample");
   pass_through_a: assert property (is_clr && clr_int_q == 16'h0 &&
      sample_valid_in |=> value_out == $past(sample_in))
      else $error("interval off not momentary");
   clear_buf_a: assert property (roll && !sample_valid_in &&
      !wr_ctrl |=> held_q == 16'h0) else $error("buffer not cleared");
   prev_take_a: assert property (roll && !sample_valid_in &&
      !wr_ctrl |=> prev_q == $past(held_q))
      else $error("previous maximum lost");
   prev_hold_a: assert property (is_clr && !roll && !wr_ctrl |=>
      $stable(prev_q)) else $error("output peak replaced early");
   delay_enter_a: assert property (dly_start |=> st_q == SM_DELAY)
      else $error("delay not started");
   below_thr_a: assert property (is_smart && sample_valid_in &&
      !above && !wr_ctrl |=> value_out == $past(sample_in) &&
      st_q == SM_IDLE) else $error("threshold pass failed");
   decay_step_a: assert property (is_smart && st_q == SM_PEAK &&
      step_vld && !sample_valid_in && held_q > 16'(step) && !wr_ctrl
      |=> held_q + 16'($past(step)) == $past(held_q))
      else $error("decay step wrong");
endmodule // tphp_picker

// >>> verification/tphp_sensor.sv
module tphp_sensor
   import tphp_pkg::*;
(
   input  wire logic             core_clk_in,
   output logic      [SMP_W-1:0] sample_out,
   output logic                  sample_valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      sample_out = 16'h5A5A;
      sample_valid_out = 1'b0;
   end
   // one sample per call; back-to-back calls keep valid high
   task automatic send(input logic [SMP_W-1:0] v);
      sample_out <= v;
      sample_valid_out <= 1'b1;
      @(posedge core_clk_in);
   endtask
   // idle bus toggles so a stale sample is never mistaken for a new one
   task automatic rest(input int n);
      repeat (n)
      begin
         sample_valid_out <= 1'b0;
         sample_out <= ~sample_out;
         @(posedge core_clk_in);
      end
   endtask
endmodule // tphp_sensor

// >>> verification/tphp_picker_tb_top.sv
module tphp_picker_tb_top
   import tphp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             core_clk_in;
   logic             rst_in;
   logic [SMP_W-1:0] sample_in;
   logic             sample_valid_in;
   logic [SMP_W-1:0] value_out;
   logic             value_valid_out;
   logic [31:0]      awaddr, wdata, araddr, rdata;
   logic [3:0]       wstrb;
   logic             awvalid, awready, wvalid, wready, bvalid, bready;
   logic             arvalid, arready, rvalid, rready;
   logic [1:0]       bresp, rresp;
   logic [31:0]      notes[$];
   int               checked, mismatches, peak_n;

   tphp_sensor u_src (.core_clk_in(core_clk_in), .sample_out(sample_in),
      .sample_valid_out(sample_valid_in));
   tphp_picker #(.TICK_CYCLES(10)) dut (.core_clk_in(core_clk_in),
      .rst_in(rst_in), .sample_in(sample_in),
      .sample_valid_in(sample_valid_in), .value_out(value_out),
      .value_valid_out(value_valid_out), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

   initial
   begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hang(input string nm);
      mismatches++;
      $display("[FAIL] %s expected answer seen none", nm);
      close_out();
   endtask

   task automatic axw(input logic [31:0] a, input logic [31:0] d,
                      output logic [1:0] r, input logic [3:0] s = 4'hF);
      bit done;
      done = 1'b0;
      r = 2'h1;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge core_clk_in);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         hang("write response");
      else
         @(posedge core_clk_in);
   endtask

   task automatic axr(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      bit done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge core_clk_in);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         hang("read response");
      else
         @(posedge core_clk_in);
   endtask

   // the note carries the expected value and an allowed spread
   task automatic smp(input logic [15:0] v, input logic [15:0] e,
                      input logic [15:0] tol = 16'h0000);
      notes.push_back({e, tol});
      u_src.send(v);
   endtask

   always @(posedge core_clk_in)
   begin
      logic [31:0] nt;
      if (value_valid_out === 1'b1)
      begin
         if (value_out === 16'h0384)
            peak_n++;
         if (notes.size() > 0)
         begin
            nt = notes.pop_front();
            chk("value_out", 32'((value_out + nt[15:0] >= nt[31:16]) &&
                (value_out <= nt[31:16] + nt[15:0])), 32'h1);
         end
      end
   end

   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] v;
      rst_in = 1'b1;
      void'($urandom(18));
      // idle payload and ready lines are don't-care, so they are random
      {awvalid, wvalid, arvalid} = 3'h0;
      {bready, rready} = 2'($urandom);
      {awaddr, wdata, araddr} = {$urandom, $urandom, $urandom};
      wstrb = 4'($urandom);
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      axr(OFS_STATUS, d, r);
      chk("status after reset", d, 32'h4);
      for (int i = 0; i < 4; i++)
      begin
         axw(OFS_CTRL, 32'(i), r);
         chk("ctrl bresp", {30'h0, r}, {30'h0, RESP_OKAY});
         axr(OFS_CTRL, d, r);
         chk("mode", d & 32'h3, 32'(i));
         axr(OFS_STATUS, d, r);
         chk("hold enable", {31'h0, d[3]}, {31'h0, i != 0});
      end
      axw(6'h24, 32'h5, r);
      chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_DECERR});
      axr(6'h24, d, r);
      chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_DECERR});
      axw(32'h8000_0000 | 32'(OFS_RBT), 32'h5, r);
      chk("high addr bresp", {30'h0, r}, {30'h0, RESP_DECERR});
      axr(OFS_RBT, d, r);
      chk("rbt kept", d, 32'h0);
      axr(32'(OFS_CTRL) | 32'h2, d, r);
      chk("unaligned rdata", d, 32'h0);
      axw(OFS_SUB_LO, 32'h1234, r);
      axw(OFS_SUB_LO, 32'h5678, r, 4'h1);
      axr(OFS_SUB_LO, d, r);
      chk("byte strobe", d, 32'h1278);
      $display("test registers done");
      axw(OFS_CLR_INT, 32'h0, r);
      axw(OFS_CTRL, {30'h0, MODE_CLR}, r);
      for (int i = 0; i < 8; i++)
      begin
         v = 16'($urandom);
         smp(v, v);
      end
      u_src.rest(4);
      $display("test interval off done");
      axw(OFS_SUB_LO, 32'h3E8, r);
      axw(OFS_CTRL, {30'h0, MODE_AUTO}, r);
      smp(16'h03FC, 16'h03FC);
      smp(16'h041A, 16'h041A);
      smp(16'h0406, 16'h041A);
      smp(16'h0384, 16'h041A);
      smp(16'h03ED, 16'h041A);
      smp(16'h03F2, 16'h03F2);
      u_src.rest(4);
      axw(OFS_SUB_LO, 32'h0, r);
      axw(OFS_FULL_LO, 32'h1F4, r);
      axw(OFS_CTRL, {30'h0, MODE_AUTO}, r);
      smp(16'h0190, 16'h0190);
      smp(16'h0320, 16'h0320);
      smp(16'h01C2, 16'h0320);
      smp(16'h0258, 16'h0258);
      u_src.rest(4);
      $display("test auto done");
      axw(OFS_RBT, 32'h1F4, r);
      axw(OFS_CTRL, {30'h0, MODE_SMART}, r);
      smp(16'h0190, 16'h0190);
      smp(16'h01F4, 16'h01F4);
      smp(16'h0320, 16'h0320);
      smp(16'h02BC, 16'h0320);
      smp(16'h0384, 16'h0384);
      smp(16'h0190, 16'h0190);
      u_src.rest(4);
      axw(OFS_DECAY, 32'h3E8, r);
      smp(16'h0320, 16'h0320);
      u_src.rest(99);
      smp(16'h0258, 16'h0316, 16'h0002);
      u_src.rest(4);
      axw(OFS_DECAY, 32'h0, r);
      axw(OFS_DELAY, 32'h5, r);
      smp(16'h0190, 16'h0190);
      smp(16'h0320, 16'h0320);
      smp(16'h0258, 16'h0258);
      u_src.rest(80);
      smp(16'h02BC, 16'h02BC);
      smp(16'h028A, 16'h02BC);
      u_src.rest(4);
      $display("test smart done");
      rst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      axr(OFS_VALUE, d, r);
      chk("value after reset", d, 32'h0);
      axr(OFS_STATUS, d, r);
      chk("status after reset", d, 32'h4);
      $display("test mid reset done");
      // interval kept well above the sensor response time
      axw(OFS_CLR_INT, 32'h2, r);
      axw(OFS_CTRL, {30'h0, MODE_CLR}, r);
      peak_n = 0;
      for (int i = 0; i < 100; i++)
         u_src.send(i == 30 ? 16'h0384 : 16'($urandom_range(16'h0320)));
      u_src.rest(4);
      chk("peak span", 32'(peak_n >= 19 && peak_n <= 21), 32'h1);
      chk("notes left", 32'(notes.size()), 32'h0);
      $display("test clear interval done");
      close_out();
   end
endmodule // tphp_picker_tb_top
